// ===== gposm_pkg.sv
// How it works
// [R1] Input enables for pins 4..0, reset to one.
// [R2] Bit 0 output enable, reset zero.
// [R3] Bits 4:2 pick the source class.
// [R4] Receive port class: selections 0-3 forward remote pins.
// [R5] Receive port: lock, pass, frame, line valid.
// [R6] Device status 000 drives local level bit.
// [R7] Device status: lock OR/AND, pass AND, trigger.
// [R8] Transmit class: AND or OR of selected status.
// [R9] Transmit class: frame, line, synchronized, interrupt.
// [R10] Bit 1 holds software output level, reset zero.
// [R11] Pin 0 and pin 1 registers, independent.
// [R12] Receiver enables gate device-status aggregated lock and pass; transmit-class pass uses port_select only.
// [R13] Read-only byte shows all eight pin levels.
// [R14] Output disabled means pin left undriven.
package gposm_pkg;
  localparam logic [7:0] GPOSM_IDX_RX_ENABLE = 8'h0C;
  localparam logic [7:0] GPOSM_IDX_PIN_LEVEL = 8'h0E;
  localparam logic [7:0] GPOSM_IDX_INPUT_EN  = 8'h0F;
  localparam logic [7:0] GPOSM_IDX_PIN0_CTL  = 8'h10;
  localparam logic [7:0] GPOSM_IDX_PIN1_CTL  = 8'h11;
  localparam logic [3:0] GPOSM_RX_ENABLE_RST = 4'hF;
  localparam logic [4:0] GPOSM_INPUT_EN_RST  = 5'h1F;
  localparam logic [7:0] GPOSM_PIN_CTL_RST   = 8'h00;
  localparam int         GPOSM_NUM_RX        = 4;
  localparam int         GPOSM_NUM_TX        = 2;
  localparam logic [1:0] GPOSM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] GPOSM_SRC_DEVICE    = 3'h4;
  localparam logic [2:0] GPOSM_SRC_RESERVED  = 3'h5;

  typedef struct packed {
    logic [2:0] selection;
    logic [2:0] source_class;
    logic       local_level;
    logic       drive_allow;
  } gposm_pin_ctl_t;

  typedef struct packed {
    logic [3:0] remote_pin;
    logic       lock;
    logic       pass;
    logic       frame_valid;
    logic       line_valid;
  } gposm_rx_stat_t;

  typedef struct packed {
    logic [3:0] port_select;
    logic       frame_valid;
    logic       line_valid;
    logic       synchronized;
    logic       interrupt;
  } gposm_tx_stat_t;
endpackage

// ===== gposm_out_mux.sv
`timescale 1ns/10ps
module gposm_out_mux import gposm_pkg::*; (
  input  wire gposm_pin_ctl_t                   ctl,
  input  wire gposm_rx_stat_t [GPOSM_NUM_RX-1:0] rx_stat,
  input  wire gposm_tx_stat_t [GPOSM_NUM_TX-1:0] tx_stat,
  input  wire logic [GPOSM_NUM_RX-1:0]          rx_allow,
  input  wire logic                             frame_trigger,
  output logic                                  level,
  output logic                                  drive
);
  logic [GPOSM_NUM_RX-1:0] en_lock;
  logic [GPOSM_NUM_RX-1:0] en_pass;
  logic [GPOSM_NUM_RX-1:0] txsel;
  gposm_rx_stat_t          rx;
  gposm_tx_stat_t          tx;

  always_comb begin
    for (int i = 0; i < GPOSM_NUM_RX; i++) begin
      en_lock[i] = rx_stat[i].lock;
      en_pass[i] = rx_stat[i].pass;
    end
    rx    = rx_stat[ctl.source_class[1:0]];
    tx    = tx_stat[ctl.source_class[0]];
    txsel = tx.port_select;
    level = 1'b0;
    if (!ctl.source_class[2]) begin
      unique case (ctl.selection) // [R3]
        3'h0, 3'h1, 3'h2, 3'h3: level = rx.remote_pin[ctl.selection[1:0]]; // [R4]
        3'h4: level = rx.lock; // [R5]
        3'h5: level = rx.pass;
        3'h6: level = rx.frame_valid;
        3'h7: level = rx.line_valid;
      endcase
    end else if (ctl.source_class == GPOSM_SRC_DEVICE) begin
      unique case (ctl.selection)
        3'h0: level = ctl.local_level; // [R6] [R10]
        // Disabled receivers drop out: neutral for OR, ignored for AND. [R12]
        3'h1: level = |(en_lock & rx_allow); // [R7]
        3'h2: level = (|rx_allow) & &(en_lock | ~rx_allow);
        3'h3: level = (|rx_allow) & &(en_pass | ~rx_allow);
        3'h4: level = frame_trigger;
        default: level = 1'b0;
      endcase
    end else if (ctl.source_class != GPOSM_SRC_RESERVED) begin
      unique case (ctl.selection)
        3'h0: level = (|txsel) & &(en_pass | ~txsel); // [R8]
        3'h1: level = |(en_pass & txsel);
        3'h2: level = tx.frame_valid; // [R9]
        3'h3: level = tx.line_valid;
        3'h4: level = tx.synchronized;
        3'h5: level = tx.interrupt;
        default: level = 1'b0;
      endcase
    end
    drive = ctl.drive_allow; // [R2] [R14]
  end
endmodule

// ===== gposm_top.sv
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module gposm_top import gposm_pkg::*; (
  input  wire logic                             hclk,
  input  wire logic                             hresetn,
  input  wire logic                             hsel,
  input  wire logic [31:0]                      haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output logic [31:0]                           hrdata,
  output logic                                  hreadyout,
  output logic                                  hresp,
  input  wire gposm_rx_stat_t [GPOSM_NUM_RX-1:0] rx_stat,
  input  wire gposm_tx_stat_t [GPOSM_NUM_TX-1:0] tx_stat,
  input  wire logic                             frame_trigger,
  input  wire logic [7:0]                       pin_in,
  output logic [1:0]                            pin_out,
  output logic [1:0]                            pin_oe,
  output logic [4:0]                            pin_input_level
);
  logic [3:0]     rx_enable_r, rx_enable_nxt;
  logic [4:0]     input_en_r, input_en_nxt;
  gposm_pin_ctl_t ctl_r [2];
  gposm_pin_ctl_t ctl_nxt [2];
  logic           wr_pend_r, wr_pend_nxt;
  logic [7:0]     wr_idx_r, wr_idx_nxt;
  logic [31:0]    hrdata_nxt;
  logic [1:0]     mux_level;
  logic [1:0]     mux_drive;
  logic [1:0]     pin_out_nxt, pin_oe_nxt;
  logic [4:0]     input_level_nxt;
  logic           take;
  logic [7:0]     idx;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel & hready & (htrans == GPOSM_HTRANS_NONSEQ);
  assign idx       = haddr[9:2];

  for (genvar p = 0; p < 2; p++) begin : g_pin
    gposm_out_mux u_mux (
      .ctl           (ctl_r[p]),
      .rx_stat       (rx_stat),
      .tx_stat       (tx_stat),
      .rx_allow      (rx_enable_r),
      .frame_trigger (frame_trigger),
      .level         (mux_level[p]),
      .drive         (mux_drive[p])
    ); // [R11]
  end

  always_comb begin
    rx_enable_nxt = rx_enable_r;
    input_en_nxt  = input_en_r;
    ctl_nxt[0]    = ctl_r[0];
    ctl_nxt[1]    = ctl_r[1];
    wr_pend_nxt   = take & hwrite;
    wr_idx_nxt    = idx;
    hrdata_nxt    = 32'h0000_0000;
    if (wr_pend_r) begin
      unique case (wr_idx_r)
        GPOSM_IDX_RX_ENABLE: rx_enable_nxt = hwdata[3:0]; // [R12]
        GPOSM_IDX_INPUT_EN:  input_en_nxt = hwdata[4:0]; // [R1]
        GPOSM_IDX_PIN0_CTL:  ctl_nxt[0] = gposm_pin_ctl_t'(hwdata[7:0]); // [R11]
        GPOSM_IDX_PIN1_CTL:  ctl_nxt[1] = gposm_pin_ctl_t'(hwdata[7:0]);
        default: ;
      endcase
    end
    if (take && !hwrite) begin
      unique case (idx)
        GPOSM_IDX_RX_ENABLE: hrdata_nxt = {28'h0, rx_enable_r};
        GPOSM_IDX_PIN_LEVEL: hrdata_nxt = {24'h0, pin_in}; // [R13]
        GPOSM_IDX_INPUT_EN:  hrdata_nxt = {27'h0, input_en_r};
        GPOSM_IDX_PIN0_CTL:  hrdata_nxt = {24'h0, ctl_r[0]};
        GPOSM_IDX_PIN1_CTL:  hrdata_nxt = {24'h0, ctl_r[1]};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
    // Undriven pins output zero and drop their enable. [R14]
    pin_oe_nxt      = mux_drive; // [R2]
    pin_out_nxt     = mux_level & mux_drive;
    // The input path only passes the pad level while enabled. [R1]
    input_level_nxt = pin_in[4:0] & input_en_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_enable_r     <= GPOSM_RX_ENABLE_RST;
      input_en_r      <= GPOSM_INPUT_EN_RST;
      ctl_r[0]        <= gposm_pin_ctl_t'(GPOSM_PIN_CTL_RST);
      ctl_r[1]        <= gposm_pin_ctl_t'(GPOSM_PIN_CTL_RST);
      wr_pend_r       <= 1'b0;
      wr_idx_r        <= 8'h00;
      hrdata          <= 32'h0000_0000;
      pin_out         <= 2'h0;
      pin_oe          <= 2'h0;
      pin_input_level <= 5'h00;
    end else begin
      rx_enable_r     <= rx_enable_nxt;
      input_en_r      <= input_en_nxt;
      ctl_r[0]        <= ctl_nxt[0];
      ctl_r[1]        <= ctl_nxt[1];
      wr_pend_r       <= wr_pend_nxt;
      wr_idx_r        <= wr_idx_nxt;
      hrdata          <= hrdata_nxt;
      pin_out         <= pin_out_nxt;
      pin_oe          <= pin_oe_nxt;
      pin_input_level <= input_level_nxt;
    end
  end
endmodule

// ===== gposm_chk.sv
`timescale 1ns/10ps
module gposm_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  pin_in,
  input wire logic [1:0]  pin_out,
  input wire logic [1:0]  pin_oe,
  input wire logic [4:0]  pin_input_level
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A taken write and its data phase; the pins follow two edges after the data edge.
  sequence s_wr(a, m, b);
    hsel && hwrite && htrans == 2'h2 && haddr == a ##1 (hwdata[4:0] & m) == b;
  endsequence
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_drive_on0: assert property (s_wr(32'h40, 5'h01, 5'h01) |-> ##2 pin_oe[0])
    else $error("pin 0 not driven after enable");
  a_drive_off1: assert property (s_wr(32'h44, 5'h01, 5'h00) |-> ##2 !pin_oe[1])
    else $error("pin 1 driven after disable");
  a_inputs_off: assert property (s_wr(32'h3C, 5'h1F, 5'h00) |-> ##2 pin_input_level == 5'h00)
    else $error("input level seen with inputs off");
  a_oe_cause: assert property ($changed(pin_oe) |->
    $past(hsel, 3) && $past(hwrite, 3) && $past(htrans, 3) == 2'h2
    && ($past(haddr, 3) == 32'h40 || $past(haddr, 3) == 32'h44))
    else $error("drive enable moved without a write");
  a_undriven_low: assert property ((pin_out & ~pin_oe) == 2'h0)
    else $error("level on undriven pin");
  a_input_gate: assert property ((~$past(pin_in) & {3'h0, pin_input_level}) == 8'h00)
    else $error("input level without pad level");
  a_unmapped_zero: assert property (hsel && !hwrite && htrans == 2'h2
    && haddr == 32'h80 |=> hrdata == 32'h0) else $error("unmapped read not zero");
endmodule
bind gposm_top gposm_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe, .pin_input_level);

// ===== gposm_far.sv
`timescale 1ns/10ps
module gposm_far import gposm_pkg::*; (
  input  wire logic                        hclk,
  input  wire logic [56:0]                 pat,
  output gposm_rx_stat_t [GPOSM_NUM_RX-1:0] rx_stat,
  output gposm_tx_stat_t [GPOSM_NUM_TX-1:0] tx_stat,
  output logic                             frame_trigger,
  output logic [7:0]                       pin_in
);
  // Board levels move only on a clock edge, so a change never races a sample.
  always_ff @(posedge hclk) {rx_stat, tx_stat, frame_trigger, pin_in} <= pat;
endmodule

// ===== gposm_top_test.sv
`timescale 1ns/10ps
module gposm_top_test;
  localparam logic [56:0] P = {32'h619E53AC, 16'h355A, 1'h1, 8'hC6};
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hresp, ft;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv, rx_s;
  logic [15:0] tx_s;
  logic [56:0] pat = P;
  logic [7:0]  pin_in;
  logic [4:0]  pil;
  logic [2:0]  hsize = 3'h2;
  logic [1:0]  htrans = 2'h0, pin_out, pin_oe;
  int          errors = 0, checked = 0, cyc = 0;
  always #20 hclk = ~hclk;
  gposm_far far (.hclk, .pat, .rx_stat(rx_s), .tx_stat(tx_s), .frame_trigger(ft), .pin_in);
  gposm_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout(hready), .hresp, .rx_stat(rx_s), .tx_stat(tx_s), .frame_trigger(ft),
    .pin_in, .pin_out, .pin_oe, .pin_input_level(pil));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'h1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    rv = hrdata;
  endtask
  function automatic logic ev(input logic [7:0] c, input logic [56:0] p, input logic [3:0] en);
    logic [2:0] s, k;
    logic [7:0] r, t;
    logic [3:0] lk, ps;
    s = c[7:5];
    k = c[4:2];
    r = p[25 + 8 * k[1:0] +: 8];
    t = p[9 + 8 * k[0] +: 8];
    for (int i = 0; i < 4; i++) begin
      lk[i] = p[28 + 8 * i];
      ps[i] = p[27 + 8 * i];
    end
    if (!c[0] || k == 3'h5) return 1'h0;
    if (!k[2]) return (s < 3'h4) ? r[4 + s] : r[7 - s];
    if (k == 3'h4) begin
      case (s)
        3'h0: return c[1];
        3'h1: return |(lk & en);
        3'h2: return (en != 4'h0) && &(lk | ~en);
        3'h3: return (en != 4'h0) && &(ps | ~en);
        3'h4: return p[8];
        default: return 1'h0;
      endcase
    end
    case (s)
      3'h0: return (t[7:4] != 4'h0) && &(ps | ~t[7:4]);
      3'h1: return |(ps & t[7:4]);
      3'h6, 3'h7: return 1'h0;
      default: return t[5 - s];
    endcase
  endfunction
  task t_reset;
    xfer(1'h0, 32'h30, 32'h0);
    chk("rx enables", rv, 32'hF);
    xfer(1'h0, 32'h3C, 32'h0);
    chk("input enables", rv, 32'h1F);
    xfer(1'h0, 32'h40, 32'h0);
    chk("pin0 control", rv, 32'h0);
    xfer(1'h0, 32'h44, 32'h0);
    chk("pin1 control", rv, 32'h0);
    chk("pins", {pin_oe, pin_out}, 32'h0);
    chk("input level", pil, 32'h6);
    $display("reset test done");
  endtask
  task t_inputs;
    xfer(1'h1, 32'h3C, 32'hE0);
    repeat (2) @(posedge hclk);
    chk("input level", pil, 32'h0);
    xfer(1'h1, 32'h3C, 32'h15);
    xfer(1'h0, 32'h3C, 32'h0);
    chk("input enables", rv, 32'h15);
    chk("input level", pil, 32'h4);
    xfer(1'h1, 32'h3C, 32'hFF);
    xfer(1'h0, 32'h3C, 32'h0);
    chk("input enables", rv, 32'h1F);
    xfer(1'h1, 32'h38, 32'h0);
    xfer(1'h0, 32'h38, 32'h0);
    chk("pin levels", rv, 32'hC6);
    xfer(1'h0, 32'h80, 32'h0);
    chk("unmapped", rv, 32'h0);
    $display("input test done");
  endtask
  task t_mux;
    logic [3:0] en, x;
    for (int n = 0; n < 2; n++) begin
      for (int e = 0; e < 3; e++) begin
        en = (e == 2) ? 4'h5 : 4'hF;
        pat <= (e == 1) ? ~P : P;
        xfer(1'h1, 32'h30, {28'h0, en});
        xfer(1'h0, 32'h30, 32'h0);
        chk("rx enables", rv, {28'h0, en});
        for (int i = 0; i < 256; i++) begin
          xfer(1'h1, 32'h40 + 4 * n, i);
          repeat (2) @(posedge hclk);
          x = 4'h0;
          x[2 + n] = i[0];
          x[n] = ev(i[7:0], pat, en);
          if (en[1] || i[4:2] == 3'h4) begin
            chk("pins", {pin_oe, pin_out}, x);
          end
        end
        xfer(1'h1, 32'h40 + 4 * n, 32'h0);
      end
    end
    $display("output mux test done");
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset;
    t_inputs;
    t_mux;
    give_verdict;
  end
endmodule
